// ==== ecr_pkg.sv ====
package ecr_pkg;

    // ****************************************************************
    // Register offsets.
    // ****************************************************************
    localparam logic [7:0] ADDR_LOGIC_FUNC = 8'h34;
    localparam logic [7:0] ADDR_LOGIC_FF = 8'h35;
    localparam logic [7:0] ADDR_LOGIC_EVENT = 8'h36;
    localparam logic [7:0] ADDR_SCAN_INTERVAL = 8'h37;
    localparam logic [7:0] ADDR_ROW_FUNC = 8'h38;
    localparam logic [7:0] ADDR_COL_FUNC = 8'h39;
    localparam logic [7:0] ADDR_ALT_FUNC = 8'h3a;
    localparam logic [7:0] ADDR_GENERAL = 8'h3b;
    localparam logic [7:0] ADDR_IRQ_ENABLE = 8'h3c;
    localparam logic [7:0] ADDR_STATUS = 8'h3f;

    // ****************************************************************
    // Writable bit masks; reserved bits are zero here.
    // ****************************************************************
    localparam logic [7:0] MASK_LOGIC_FUNC = 8'h07;
    localparam logic [7:0] MASK_LOGIC_FF = 8'h03;
    localparam logic [7:0] MASK_LOGIC_EVENT = 8'h07;
    localparam logic [7:0] MASK_SCAN_INTERVAL = 8'h03;
    localparam logic [7:0] MASK_ROW_FUNC = 8'h3f;
    localparam logic [7:0] MASK_COL_FUNC = 8'h1f;
    localparam logic [7:0] MASK_ALT_FUNC = 8'hed;
    localparam logic [7:0] MASK_GENERAL = 8'he3;
    localparam logic [7:0] MASK_IRQ_ENABLE = 8'h17;
    localparam logic [7:0] RESET_VALUE = 8'h00;

    // ****************************************************************
    // Field positions.
    // ****************************************************************
    localparam int FLIPFLOP_SET_BIT_POS = 1;
    localparam int FLIPFLOP_CLEAR_BIT_POS = 0;
    localparam int DBNC_BYPASS_POS = 2;
    localparam int EVENT_EN_POS = 1;
    localparam int ACTIVE_LEVEL_POS = 0;
    localparam int PULL_SEL_POS = 7;
    localparam int COL4_RESET_POS = 6;
    localparam int ROW4_RESET_POS = 5;
    localparam int ROW3_ALT_LSB = 2;
    localparam int ROW0_LOGIC_POS = 0;
    localparam int BASE_OSCILLATOR_ENABLE_POS = 7;
    localparam int CORE_DIV_LSB = 5;
    localparam int IRQ_CLEAR_MODE_POS = 1;
    localparam int RESET_RESPONSE_POS = 0;
    localparam int IEN_LOGIC_POS = 4;
    localparam int IEN_OVERFLOW_POS = 2;
    localparam int IEN_INPUT_POS = 1;
    localparam int IEN_KEY_POS = 0;

    // ****************************************************************
    // Encodings.
    // ****************************************************************
    localparam logic [1:0] ROW3_LOGIC_IN = 2'h1;
    localparam logic [1:0] ROW3_PWM_OUT = 2'h2;
    localparam logic [2:0] FUNC_FLIPFLOP = 3'h4;

    // ****************************************************************
    // Timing.
    // ****************************************************************
    localparam int CLK_HZ = 10_000_000;
    localparam int SCAN_STEP_MS = 10;
    localparam int SCAN_STEP_CYCLES = CLK_HZ / 1000 * SCAN_STEP_MS;
    localparam int IRQ_GAP_US = 50;
    localparam int IRQ_GAP_CYCLES = (CLK_HZ / 1_000_000) * IRQ_GAP_US;
    localparam int CORE_KHZ_50 = 50;
    localparam int CORE_KHZ_100 = 100;
    localparam int CORE_KHZ_200 = 200;
    localparam int CORE_KHZ_500 = 500;
    localparam int DBNC_CORE_TICKS = 3;

endpackage

// ==== ecr_regs.sv ====
// Design decision made here: the plain strobed port.
`timescale 1ns/1ps
module ecr_regs #(
    parameter int SCAN_STEP = ecr_pkg::SCAN_STEP_CYCLES
) (
    // Clock and reset.
    input wire logic clk_sys,
    input wire logic nrst,
    // Register port.
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    // Pins, asynchronous to clk_sys.
    input wire logic logic_in_a,
    input wire logic logic_in_b,
    input wire logic row3_pin_in,
    input wire logic rst_pin_n,
    // Interrupt sources and clear from the rest of the core.
    input wire logic key_event_flag,
    input wire logic overflow_flag,
    input wire logic input_change_flag,
    input wire logic irq_clear,
    // Logic block results.
    output logic logic_output,
    output logic logic_event,
    // Pin function steering.
    output logic [5:0] row_key_mode,
    output logic [4:0] col_key_mode,
    output logic row_pull_strong,
    output logic col4_reset_two_select,
    output logic row4_reset_one_select,
    output logic row3_logic_in_select,
    output logic row3_pwm_select,
    output logic row0_logic_out_select,
    // Clocking, scanning, reset and interrupt line.
    output logic base_oscillator_enable,
    output logic core_tick,
    output logic scan_tick,
    output logic device_reset,
    output logic irq_n
);

    // ****************************************************************
    // Storage.
    // ****************************************************************
    logic [7:0] logic_func, logic_ff_ctrl, logic_event_ctrl, scan_interval, row_func;
    logic [7:0] col_func, alt_func, general, irq_enable, core_cnt, next_rdata;
    logic logic_flipflop, logic_flag, logic_raw, logic_clean, logic_active_q;
    logic wr_ff, irq_pending, logic_sel, logic_active;
    logic [1:0] sync_a, sync_b, sync_c, sync_rst, dbnc_cnt;
    logic [17:0] scan_cnt;
    logic [2:0] scan_step_cnt;
    logic [9:0] gap_cnt;

    // Core tick period in clk_sys cycles for a divider code.
    function automatic logic [7:0] core_period(input logic [1:0] code);
        int khz;
        khz = ecr_pkg::CORE_KHZ_50;
        unique case (code)
            2'h0: khz = ecr_pkg::CORE_KHZ_50;
            2'h1: khz = ecr_pkg::CORE_KHZ_100;
            2'h2: khz = ecr_pkg::CORE_KHZ_200;
            2'h3: khz = ecr_pkg::CORE_KHZ_500;
        endcase
        core_period = 8'((ecr_pkg::CLK_HZ / 1000) / khz);
    endfunction

    // ****************************************************************
    // Register writes.
    // ****************************************************************
    // reserved bits masked
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            logic_func <= ecr_pkg::RESET_VALUE;
            logic_ff_ctrl <= ecr_pkg::RESET_VALUE;
            logic_event_ctrl <= ecr_pkg::RESET_VALUE;
            scan_interval <= ecr_pkg::RESET_VALUE;
            row_func <= ecr_pkg::RESET_VALUE;
            col_func <= ecr_pkg::RESET_VALUE;
            alt_func <= ecr_pkg::RESET_VALUE;
            general <= ecr_pkg::RESET_VALUE;
            irq_enable <= ecr_pkg::RESET_VALUE;
            row3_logic_in_select <= 1'b0;
            row3_pwm_select <= 1'b0;
        end else if (reg_wr) begin
            unique case (reg_addr)
                ecr_pkg::ADDR_LOGIC_FUNC:
                    logic_func <= reg_wdata & ecr_pkg::MASK_LOGIC_FUNC;
                ecr_pkg::ADDR_LOGIC_FF:
                    logic_ff_ctrl <= reg_wdata & ecr_pkg::MASK_LOGIC_FF;
                ecr_pkg::ADDR_LOGIC_EVENT:
                    logic_event_ctrl <= reg_wdata & ecr_pkg::MASK_LOGIC_EVENT;
                ecr_pkg::ADDR_SCAN_INTERVAL:
                    scan_interval <= reg_wdata & ecr_pkg::MASK_SCAN_INTERVAL;
                ecr_pkg::ADDR_ROW_FUNC:
                    row_func <= reg_wdata & ecr_pkg::MASK_ROW_FUNC;
                ecr_pkg::ADDR_COL_FUNC:
                    col_func <= reg_wdata & ecr_pkg::MASK_COL_FUNC;
                // row 3 decode, registered at the write.
                ecr_pkg::ADDR_ALT_FUNC: begin
                    alt_func <= reg_wdata & ecr_pkg::MASK_ALT_FUNC;
                    row3_logic_in_select <= reg_wdata[3:2] == ecr_pkg::ROW3_LOGIC_IN;
                    row3_pwm_select <= reg_wdata[3:2] == ecr_pkg::ROW3_PWM_OUT;
                end
                ecr_pkg::ADDR_GENERAL:
                    general <= reg_wdata & ecr_pkg::MASK_GENERAL;
                ecr_pkg::ADDR_IRQ_ENABLE:
                    irq_enable <= reg_wdata & ecr_pkg::MASK_IRQ_ENABLE;
                default: ;
            endcase
        end
    end

    // ****************************************************************
    // Register reads, data one cycle after the strobe.
    // ****************************************************************
    always_comb begin
        next_rdata = 8'h00;
        unique case (reg_addr)
            ecr_pkg::ADDR_LOGIC_FUNC: next_rdata = logic_func;
            ecr_pkg::ADDR_LOGIC_FF: next_rdata = logic_ff_ctrl;
            ecr_pkg::ADDR_LOGIC_EVENT: next_rdata = logic_event_ctrl;
            ecr_pkg::ADDR_SCAN_INTERVAL: next_rdata = scan_interval;
            ecr_pkg::ADDR_ROW_FUNC: next_rdata = row_func;
            ecr_pkg::ADDR_COL_FUNC: next_rdata = col_func;
            ecr_pkg::ADDR_ALT_FUNC: next_rdata = alt_func;
            ecr_pkg::ADDR_GENERAL: next_rdata = general;
            ecr_pkg::ADDR_IRQ_ENABLE: next_rdata = irq_enable;
            ecr_pkg::ADDR_STATUS: next_rdata = {4'h0, ~irq_n, logic_flag,
                                                logic_active_q, logic_flipflop};
            default: next_rdata = 8'h00;
        endcase
    end

    // Read data stands only in the cycle after the strobe, zero otherwise.
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            reg_rdata <= 8'h00;
        end else begin
            reg_rdata <= reg_rd ? next_rdata : 8'h00;
        end
    end

    // ****************************************************************
    // Pin synchronisers.
    // ****************************************************************
    // Two stages each; only the second stage feeds logic.
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            sync_a <= 2'h0;
            sync_b <= 2'h0;
            sync_c <= 2'h0;
            sync_rst <= 2'h3;
        end else begin
            sync_a <= {sync_a[0], logic_in_a};
            sync_b <= {sync_b[0], logic_in_b};
            sync_c <= {sync_c[0], row3_pin_in};
            sync_rst <= {sync_rst[0], rst_pin_n};
        end
    end

    // ****************************************************************
    // Logic block flip-flop.
    // ****************************************************************
    assign wr_ff = reg_wr && (reg_addr == ecr_pkg::ADDR_LOGIC_FF);

    // Clear is checked last so a write with both bits ends cleared.
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            logic_flipflop <= 1'b0;
        end else if (wr_ff) begin
            if (reg_wdata[ecr_pkg::FLIPFLOP_SET_BIT_POS]) begin
                logic_flipflop <= 1'b1;
            end
            if (reg_wdata[ecr_pkg::FLIPFLOP_CLEAR_BIT_POS]) begin
                logic_flipflop <= 1'b0;
            end
        end
    end

    // ****************************************************************
    // Logic function and output.
    // ****************************************************************
    // function selector
    always_comb begin
        logic_sel = 1'b0;
        unique case (logic_func[2:0])
            3'h0: logic_sel = 1'b0;
            3'h1: logic_sel = sync_a[1] & sync_b[1];
            3'h2: logic_sel = sync_a[1] | sync_b[1];
            3'h3: logic_sel = sync_a[1] ^ sync_b[1];
            ecr_pkg::FUNC_FLIPFLOP: logic_sel = logic_flipflop;
            3'h5: logic_sel = sync_a[1];
            3'h6: logic_sel = sync_b[1];
            3'h7: logic_sel = row3_logic_in_select & sync_c[1];
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            logic_raw <= 1'b0;
        end else begin
            logic_raw <= logic_sel;
        end
    end

    assign logic_output = logic_raw;

    // ****************************************************************
    // Core clock tick from the base oscillator.
    // ****************************************************************
    // oscillator gates core
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            core_cnt <= 8'h00;
            core_tick <= 1'b0;
        end else if (!general[ecr_pkg::BASE_OSCILLATOR_ENABLE_POS]) begin
            core_cnt <= 8'h00;
            core_tick <= 1'b0;
        end else if (core_cnt >= core_period(general[6:5]) - 8'h01) begin
            core_cnt <= 8'h00;
            core_tick <= 1'b1;
        end else begin
            core_cnt <= core_cnt + 8'h01;
            core_tick <= 1'b0;
        end
    end

    // ****************************************************************
    // Debounce of the logic output, counted in core ticks.
    // ****************************************************************
    // A stopped oscillator freezes the debounced value; use bypass then.
    // debounce or bypass
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            dbnc_cnt <= 2'h0;
            logic_clean <= 1'b0;
        end else if (logic_event_ctrl[ecr_pkg::DBNC_BYPASS_POS]) begin
            dbnc_cnt <= 2'h0;
            logic_clean <= logic_raw;
        end else if (logic_raw == logic_clean) begin
            dbnc_cnt <= 2'h0;
        end else if (core_tick) begin
            if (dbnc_cnt == 2'(ecr_pkg::DBNC_CORE_TICKS - 1)) begin
                dbnc_cnt <= 2'h0;
                logic_clean <= logic_raw;
            end else begin
                dbnc_cnt <= dbnc_cnt + 2'h1;
            end
        end
    end

    assign logic_active = logic_clean ~^ logic_event_ctrl[ecr_pkg::ACTIVE_LEVEL_POS];

    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            logic_active_q <= 1'b0;
            logic_event <= 1'b0;
        end else begin
            logic_active_q <= logic_active;
            logic_event <= logic_event_ctrl[ecr_pkg::EVENT_EN_POS] &&
                           (logic_active != logic_active_q);
        end
    end

    // Sticky logic flag; a new event beats a clear in the same cycle.
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            logic_flag <= 1'b0;
        end else if (logic_event && logic_active_q) begin
            logic_flag <= 1'b1;
        end else if (irq_clear) begin
            logic_flag <= 1'b0;
        end
    end

    // ****************************************************************
    // Scan interval timer.
    // ****************************************************************
    // interval in 10 ms steps
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            scan_cnt <= 18'h0;
            scan_step_cnt <= 3'h0;
            scan_tick <= 1'b0;
        end else if (scan_cnt != 18'(SCAN_STEP - 1)) begin
            scan_cnt <= scan_cnt + 18'h1;
            scan_tick <= 1'b0;
        end else if (scan_step_cnt >= {1'b0, scan_interval[1:0]}) begin
            scan_cnt <= 18'h0;
            scan_step_cnt <= 3'h0;
            scan_tick <= 1'b1;
        end else begin
            scan_cnt <= 18'h0;
            scan_step_cnt <= scan_step_cnt + 3'h1;
            scan_tick <= 1'b0;
        end
    end

    // ****************************************************************
    // Pin function steering, straight from register bits.
    // ****************************************************************
    // row duty
    assign row_key_mode = row_func[5:0];
    assign col_key_mode = col_func[4:0];
    assign row_pull_strong = alt_func[ecr_pkg::PULL_SEL_POS];
    assign col4_reset_two_select = alt_func[ecr_pkg::COL4_RESET_POS];
    assign row4_reset_one_select = alt_func[ecr_pkg::ROW4_RESET_POS];
    assign row0_logic_out_select = alt_func[ecr_pkg::ROW0_LOGIC_POS];
    assign base_oscillator_enable = general[ecr_pkg::BASE_OSCILLATOR_ENABLE_POS];

    // ****************************************************************
    // External reset pin response.
    // ****************************************************************
    // The bank itself is not reset by this, so the mask bit survives.
    // reset response
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            device_reset <= 1'b0;
        end else begin
            device_reset <= !sync_rst[1] && !general[ecr_pkg::RESET_RESPONSE_POS];
        end
    end

    // ****************************************************************
    // Interrupt line.
    // ****************************************************************
    // per source enables
    assign irq_pending = (logic_flag & irq_enable[ecr_pkg::IEN_LOGIC_POS]) |
                         (overflow_flag & irq_enable[ecr_pkg::IEN_OVERFLOW_POS]) |
                         (input_change_flag & irq_enable[ecr_pkg::IEN_INPUT_POS]) |
                         (key_event_flag & irq_enable[ecr_pkg::IEN_KEY_POS]);

    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            gap_cnt <= 10'h0;
        end else if (irq_clear && irq_pending && general[ecr_pkg::IRQ_CLEAR_MODE_POS]) begin
            gap_cnt <= 10'(ecr_pkg::IRQ_GAP_CYCLES);
        end else if (gap_cnt != 10'h0) begin
            gap_cnt <= gap_cnt - 10'h1;
        end
    end

    // The line is low while a source is pending and no gap runs.
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            irq_n <= 1'b1;
        end else if (irq_clear && irq_pending && general[ecr_pkg::IRQ_CLEAR_MODE_POS]) begin
            irq_n <= 1'b1;
        end else begin
            irq_n <= !(irq_pending && (gap_cnt <= 10'h1));
        end
    end

endmodule

// ==== ecr_regs_sva.sv ====
`timescale 1ns/1ps
// ****************************************************************
// Port checker for the configuration bank.
// ****************************************************************
module ecr_regs_sva (
    // Clock and reset.
    input wire logic clk_sys,
    input wire logic nrst,
    // Register port.
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    // Source flag and clear.
    input wire logic key_event_flag,
    input wire logic irq_clear,
    // Observed results.
    input wire logic logic_event,
    input wire logic [5:0] row_key_mode,
    input wire logic [4:0] col_key_mode,
    input wire logic row3_logic_in_select,
    input wire logic row3_pwm_select,
    input wire logic base_oscillator_enable,
    input wire logic core_tick,
    input wire logic scan_tick,
    input wire logic device_reset,
    input wire logic irq_n
);
    // One clock domain; reset suspends every check.
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!nrst);
    // Per-register write strobes keep the properties short.
    wire logic w_row = reg_wr && reg_addr == ecr_pkg::ADDR_ROW_FUNC;
    wire logic w_col = reg_wr && reg_addr == ecr_pkg::ADDR_COL_FUNC;
    wire logic w_alt = reg_wr && reg_addr == ecr_pkg::ADDR_ALT_FUNC;
    wire logic w_evt = reg_wr && reg_addr == ecr_pkg::ADDR_LOGIC_EVENT;
    wire logic w_gen = reg_wr && reg_addr == ecr_pkg::ADDR_GENERAL;
    wire logic w_ien = reg_wr && reg_addr == ecr_pkg::ADDR_IRQ_ENABLE;
    // Read data and steering follow the port.
    a_read_idle_zero: assert property (!reg_rd |=> reg_rdata == 8'h00)
        else $error("idle read data");
    a_unmapped_zero: assert property (reg_rd && reg_addr > 8'h3f |=> reg_rdata == 8'h00)
        else $error("unmapped read");
    a_row_mode_write: assert property (w_row |=> row_key_mode == $past(reg_wdata[5:0]))
        else $error("row mode");
    a_col_mode_write: assert property (w_col |=> col_key_mode == $past(reg_wdata[4:0]))
        else $error("column mode");
    a_row3_decode: assert property (w_alt |=>
        row3_pwm_select == ($past(reg_wdata[3:2]) == ecr_pkg::ROW3_PWM_OUT) &&
        row3_logic_in_select == ($past(reg_wdata[3:2]) == ecr_pkg::ROW3_LOGIC_IN))
        else $error("row 3 decode");
    a_osc_write: assert property (w_gen |=> base_oscillator_enable == $past(reg_wdata[7]))
        else $error("oscillator enable");
    a_core_tick_stop: assert property (!base_oscillator_enable &&
        $past(base_oscillator_enable) == 1'b0 |-> !core_tick)
        else $error("stray core tick");
    // A cleared enable or the set reset mask bit silences its output; a clear opens a gap.
    a_event_gate: assert property (w_evt && !reg_wdata[1] ##1 !w_evt |=> !logic_event)
        else $error("gated logic event");
    a_irq_masked: assert property (w_ien && reg_wdata == 8'h00 ##1 !w_ien |=> irq_n)
        else $error("masked interrupt");
    a_reset_masked: assert property (w_gen && reg_wdata[0] ##1 !w_gen |=> !device_reset)
        else $error("masked pin reset");
    a_clear_gap: assert property ($rose(irq_n) && $past(irq_clear) && key_event_flag |->
        irq_n [*8])
        else $error("short gap");
    // Main scenarios seen.
    c_scan: cover property (scan_tick);
    c_event: cover property (logic_event);
    c_gap: cover property ($rose(irq_n) && $past(irq_clear));
endmodule

bind ecr_regs ecr_regs_sva u_sva (.clk_sys, .nrst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .key_event_flag, .irq_clear, .logic_event, .row_key_mode, .col_key_mode,
    .row3_logic_in_select, .row3_pwm_select, .base_oscillator_enable, .core_tick, .scan_tick,
    .device_reset, .irq_n);

// ==== test_expander_config_registers.sv ====
`timescale 1ns/1ps
module test_expander_config_registers;
    // ****************************************************************
    // Stimulus, design and bookkeeping.
    // ****************************************************************
    logic clk_sys = 1'b0;
    logic nrst = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic rst_pin_n = 1'b1;
    logic irq_clear = 1'b0;
    logic [2:0] flags = 3'h0;
    logic [1:0] sel = 2'h0;
    logic [7:0] d;
    int n;
    int err_total = 0;
    int checked = 0;
    int cyc = 0;
    wire [7:0] reg_rdata;
    wire [5:0] row_key_mode;
    wire [4:0] col_key_mode;
    wire logic_output, logic_event, row_pull_strong, col4_reset_two_select;
    wire row4_reset_one_select, row3_logic_in_select, row3_pwm_select, row0_logic_out_select;
    wire base_oscillator_enable, core_tick, scan_tick, device_reset, irq_n;
    wire tk = sel == 0 ? core_tick : sel == 1 ? scan_tick : sel == 2 ? logic_event : !irq_n;
    logic [7:0] adr [10] = '{8'h34, 8'h35, 8'h36, 8'h37, 8'h38, 8'h39, 8'h3a, 8'h3b, 8'h3c, 8'h40};
    logic [7:0] msk [10] = '{8'h07, 8'h03, 8'h07, 8'h03, 8'h3f, 8'h1f, 8'hed, 8'he3, 8'h17, 8'h00};
    logic [7:0] alt [7] = '{8'h80, 8'h40, 8'h20, 8'h01, 8'h04, 8'h08, 8'h0c};
    logic [5:0] altx [7] = '{6'h20, 6'h10, 6'h08, 6'h04, 6'h02, 6'h01, 6'h00};
    logic [7:0] ffw [6] = '{8'h02, 8'h00, 8'h01, 8'h00, 8'h02, 8'h03};
    logic [5:0] ffx = 6'b010011;
    int cper [4] = '{200, 100, 50, 20};

    // The short scan step keeps the interval checks quick.
    ecr_regs #(.SCAN_STEP(20)) DUT (.clk_sys, .nrst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
        .reg_rdata, .logic_in_a(1'b0), .logic_in_b(1'b0), .row3_pin_in(1'b0), .rst_pin_n,
        .key_event_flag(flags[0]), .overflow_flag(flags[2]), .input_change_flag(flags[1]),
        .irq_clear, .logic_output, .logic_event, .row_key_mode, .col_key_mode, .row_pull_strong,
        .col4_reset_two_select, .row4_reset_one_select, .row3_logic_in_select, .row3_pwm_select,
        .row0_logic_out_select, .base_oscillator_enable, .core_tick, .scan_tick, .device_reset,
        .irq_n);

    // Clock and hang guard; the ceiling is well above the expected run.
    always #50 clk_sys = ~clk_sys;
    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        if (cyc == 30000) begin
            err_total++;
            give_verdict();
        end
    end

    // ****************************************************************
    // Port tasks.
    // ****************************************************************
    task automatic give_verdict();
        if (err_total == 0 && checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task automatic chk(string nm, logic [15:0] e, logic [15:0] g);
        checked++;
        if (g !== e) begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask
    // Returns at the falling edge after the write.
    task automatic wr(logic [7:0] a, logic [7:0] v);
        @(posedge clk_sys);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= v;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
        @(negedge clk_sys);
    endtask
    task automatic rd(logic [7:0] a);
        @(posedge clk_sys);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        @(negedge clk_sys);
        d = reg_rdata;
    endtask
    task automatic clr();
        @(posedge clk_sys);
        irq_clear <= 1'b1;
        @(posedge clk_sys);
        irq_clear <= 1'b0;
    endtask
    // Counts falling edges until the selected signal is high, at most lim.
    task automatic till(logic [1:0] s, int lim);
        sel = s;
        n = 0;
        do begin
            @(negedge clk_sys);
            n++;
        end while (tk !== 1'b1 && n < lim);
    endtask

    // ****************************************************************
    // Test sequence.
    // ****************************************************************
    initial begin
        repeat (20) @(posedge clk_sys);
        nrst <= 1'b1;
        for (int i = 0; i < 10; i++) begin
            rd(adr[i]);
            chk("reset value", 8'h00, d);
            wr(adr[i], 8'hff);
            rd(adr[i]);
            chk("masked readback", msk[i], d);
        end
        chk("row mode", 6'h3f, row_key_mode);
        chk("column mode", 5'h1f, col_key_mode);
        for (int i = 0; i < 7; i++) begin
            wr(8'h3a, alt[i]);
            chk("alt steering", altx[i], {row_pull_strong, col4_reset_two_select,
                row4_reset_one_select, row0_logic_out_select, row3_logic_in_select,
                row3_pwm_select});
        end
        // Set, hold, clear and set-with-clear of the logic flip-flop.
        wr(8'h34, {5'h00, ecr_pkg::FUNC_FLIPFLOP});
        for (int i = 0; i < 6; i++) begin
            wr(8'h35, ffw[i]);
            repeat (2) @(negedge clk_sys);
            chk("flip-flop output", ffx[i], logic_output);
        end
        // Undebounced, active high: prompt event, flag and line.
        wr(8'h35, 8'h02);
        till(2'd2, 20);
        chk("prompt event", 1'b1, n < 20);
        rd(8'h3f);
        chk("status high", 8'h0f, d);
        // Active low: the same level now reads inactive.
        wr(8'h3b, 8'he1);
        wr(8'h36, 8'h06);
        clr();
        rd(8'h3f);
        chk("status low", 8'h01, d);
        wr(8'h35, 8'h01);
        till(2'd2, 20);
        chk("low event", 1'b1, n < 20);
        clr();
        wr(8'h36, 8'h05);
        wr(8'h35, 8'h02);
        till(2'd2, 30);
        chk("disabled event", 30, n);
        // Debounced at the fastest core clock: no early event.
        wr(8'h36, 8'h03);
        wr(8'h35, 8'h01);
        till(2'd2, 10);
        chk("debounce hold", 10, n);
        till(2'd2, 200);
        chk("debounced event", 1'b1, n < 200);
        for (int i = 0; i < 4; i++) begin
            wr(8'h3b, {1'b1, i[1:0], 5'h00});
            till(2'd0, 1000);
            till(2'd0, 1000);
            chk("core period", cper[i], n);
        end
        wr(8'h3b, 8'h00);
        till(2'd0, 400);
        chk("oscillator off", {1'b0, 15'd400}, {base_oscillator_enable, 15'(n)});
        for (int i = 0; i < 4; i++) begin
            wr(8'h37, 8'(i));
            till(2'd1, 500);
            till(2'd1, 500);
            chk("scan period", (i + 1) * 20, n);
        end
        // Key, input-change and overflow sources alone, masked then enabled.
        for (int i = 0; i < 3; i++) begin
            @(posedge clk_sys);
            flags <= 3'h1 << i;
            wr(8'h3c, 8'h00);
            @(negedge clk_sys);
            chk("irq masked", 1'b1, irq_n);
            wr(8'h3c, 8'h01 << i);
            @(negedge clk_sys);
            chk("irq enabled", 1'b0, irq_n);
        end
        @(posedge clk_sys);
        flags <= 3'h1;
        wr(8'h3c, 8'h01);
        clr();
        repeat (3) @(negedge clk_sys);
        chk("irq held", 1'b0, irq_n);
        wr(8'h3b, 8'h02);
        clr();
        till(2'd3, 1000);
        chk("irq gap", ecr_pkg::IRQ_GAP_CYCLES + 1, n);
        // External reset pin, obeyed then ignored.
        @(posedge clk_sys);
        rst_pin_n <= 1'b0;
        repeat (5) @(negedge clk_sys);
        chk("pin reset", 1'b1, device_reset);
        wr(8'h3b, 8'h03);
        @(negedge clk_sys);
        chk("pin ignored", 1'b0, device_reset);
        give_verdict();
    end
endmodule
